// ===== logic/cpmc_pkg.sv
// Package for the core performance counter control block.
// Assumes one core clock and register accesses on the documented access port.
package cpmc_pkg;

  // ==========================================================
  // Sizes
  localparam int GP_COUNT = 8;         // Counters per core
  localparam int GP_SHARED_COUNT = 4;  // Visible when the core is shared
  localparam int EBS_COUNT = 4;        // Counters able to sample
  localparam int FIX_COUNT = 3;        // Fixed-function counters
  localparam int CTR_W = 48;           // Counter width
  localparam int EVSEL_W = 32;         // Stored event-select width
  localparam int FIXCTL_W = 12;        // Fixed counter control width
  localparam int ADDR_W = 12;          // Register address width
  localparam int SEXT_W = 32;          // Width of a normal counter write

  // ==========================================================
  // Register addresses
  localparam logic [11:0] ADDR_GP_CTR_BASE = 12'h0c1;  // Counters 0..7
  localparam logic [11:0] ADDR_GP_CTR4 = 12'h0c5;
  localparam logic [11:0] ADDR_GP_CTR7 = 12'h0c8;
  localparam logic [11:0] ADDR_EVSEL_BASE = 12'h200;
  localparam logic [11:0] ADDR_ALIAS_BASE = 12'h2c0;
  localparam logic [11:0] ADDR_FIX_CTR_BASE = 12'h300;
  localparam logic [11:0] ADDR_FIX_CTRL = 12'h310;
  localparam logic [11:0] ADDR_CAPABILITY = 12'h320;
  localparam logic [11:0] ADDR_GLOBAL_STATUS = 12'h321;
  localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'h322;
  localparam logic [11:0] ADDR_OVF_CLEAR = 12'h323;
  localparam logic [11:0] ADDR_EBS_ENABLE = 12'h324;
  localparam logic [11:0] ADDR_FREEZE_CTRL = 12'h325;
  localparam logic [11:0] ADDR_OFFCORE_0 = 12'h1a6;
  localparam logic [11:0] ADDR_OFFCORE_1 = 12'h1a7;

  // ==========================================================
  // Field positions
  localparam int ENUM_GP_LSB = 8;        // Counter count in bits 15:8
  localparam int CAP_FW_WRITE_BIT = 13;  // Full-width write support
  localparam int STAT_BUF_OVF_BIT = 62;  // Sample buffer overflow
  localparam int FIX_LSB = 32;           // Fixed bits in global regs
  localparam int HI_LSB = 4;             // Bits 7:4 of global regs
  localparam int HI_MSB = 7;
  localparam int EVSEL_USR_BIT = 16;
  localparam int EVSEL_OS_BIT = 17;
  localparam int FIXCTL_OS_BIT = 0;
  localparam int FIXCTL_USR_BIT = 1;
  localparam int FIXCTL_STRIDE = 4;
  localparam int FRZ_CTR_BIT = 0;
  localparam int FRZ_BR_BIT = 1;
  localparam int FRZ_SMM_BIT = 2;

  // ==========================================================
  // Values and reset values
  localparam logic [7:0] PMU_VERSION = 8'h03;
  localparam logic [7:0] ENUM_CNT_SHARED = 8'h04;
  localparam logic [7:0] ENUM_CNT_FULL = 8'h08;
  localparam logic [47:0] CTR_RESET = 48'h0000_0000_0000;
  localparam logic [31:0] EVSEL_RESET = 32'h0000_0000;
  localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;

endpackage

// ===== logic/cpmc_counter.sv
// One event counter with load and wrap detection.
// Assumes load takes priority over counting in the same cycle.
`timescale 1ns/1ps
module cpmc_counter #(
  parameter int W = 48
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic inc,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // State
  output logic [W-1:0] count_ff,
  output logic wrap
);

  // ==========================================================
  // Wrap from all ones to zero; a load hides the increment
  assign wrap = inc & ~load & (&count_ff);

  // Counter register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= load_val;
    end else if (inc) begin
      count_ff <= count_ff + 1'b1;
    end
  end

endmodule

// ===== logic/cpmc_core_ctl.sv
// Core performance counter control: eight general counters, three fixed
// counters, global enable, status, overflow clear, sampling arm/store.
// Assumes event pulses already selected per counter by core event logic,
// and a sampling store engine that reports bounds and buffer state.
`timescale 1ns/1ps
module cpmc_core_ctl
  import cpmc_pkg::*;
#(
  parameter int NUM_GP = GP_COUNT,
  parameter int NUM_FIX = FIX_COUNT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access port
  input wire logic msr_req,
  input wire logic msr_wr,
  input wire logic [ADDR_W-1:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  output logic msr_ack,
  output logic msr_fault,
  output logic [63:0] msr_rdata,
  // Core state
  input wire logic core_shared,
  input wire logic cpl_user,
  input wire logic smm_active,
  input wire logic monitor_irq,
  // Event sources
  input wire logic [NUM_GP-1:0] gp_event,
  input wire logic [NUM_FIX-1:0] fixed_event,
  // Sampling store engine
  input wire logic ds_bounds_ok,
  input wire logic ds_buffer_full,
  input wire logic [CTR_W-1:0] ds_reload_value,
  output logic record_store,
  output logic [1:0] record_ctr,
  // Configuration and enumeration out
  output logic [31:0] enum_result,
  output logic [NUM_GP*EVSEL_W-1:0] gp_evsel_flat,
  output logic [63:0] offcore_cfg0,
  output logic [63:0] offcore_cfg1,
  output logic branch_record_freeze
);

  // ==========================================================
  // State
  logic [NUM_GP-1:0] gctrl_gp_ff;       // Global enables, general
  logic [NUM_FIX-1:0] gctrl_fix_ff;     // Global enables, fixed
  logic [NUM_GP-1:0] gp_ovf_ff;         // Overflow flags, general
  logic [NUM_FIX-1:0] fix_ovf_ff;       // Overflow flags, fixed
  logic buf_ovf_ff;                     // Sample buffer overflow
  logic [EBS_COUNT-1:0] ebs_en_ff;      // Sampling enables
  logic [EBS_COUNT-1:0] armed_ff;       // Sampling armed
  logic [2:0] frz_ff;                   // Freeze options
  logic [FIXCTL_W-1:0] fixctl_ff;       // Fixed counter control
  logic [EVSEL_W-1:0] evsel_ff [NUM_GP];
  logic [63:0] off0_ff;
  logic [63:0] off1_ff;
  logic br_frz_ff;
  logic ack_ff;
  logic fault_ff;
  logic [63:0] rdata_ff;
  logic store_ff;
  logic [1:0] store_idx_ff;
  logic [31:0] enum_ff;
  logic [CTR_W-1:0] gp_cnt [NUM_GP];
  logic [CTR_W-1:0] fix_cnt [NUM_FIX];
  logic [NUM_GP-1:0] gp_wrap;
  logic [NUM_FIX-1:0] fix_wrap;

  // ==========================================================
  // Address decode
  wire acc_wr = msr_req & msr_wr;
  wire [ADDR_W-1:0] gp_off = msr_addr - ADDR_GP_CTR_BASE;
  wire [ADDR_W-1:0] al_off = msr_addr - ADDR_ALIAS_BASE;
  wire [ADDR_W-1:0] ev_off = msr_addr - ADDR_EVSEL_BASE;
  wire [ADDR_W-1:0] fx_off = msr_addr - ADDR_FIX_CTR_BASE;
  wire hit_gp = gp_off < ADDR_W'(NUM_GP);
  wire hit_al = al_off < ADDR_W'(NUM_GP);
  wire hit_ev = ev_off < ADDR_W'(NUM_GP);
  wire hit_fx = fx_off < ADDR_W'(NUM_FIX);
  wire [2:0] gp_idx = gp_off[2:0];
  wire [2:0] al_idx = al_off[2:0];
  wire [2:0] ev_idx = ev_off[2:0];
  wire [1:0] fx_idx = fx_off[1:0];
  wire hit_ctrl = msr_addr == ADDR_GLOBAL_CTRL;
  wire hit_stat = msr_addr == ADDR_GLOBAL_STATUS;
  wire hit_oclr = msr_addr == ADDR_OVF_CLEAR;
  wire hit_fxc = msr_addr == ADDR_FIX_CTRL;
  wire hit_cap = msr_addr == ADDR_CAPABILITY;
  wire hit_ebs = msr_addr == ADDR_EBS_ENABLE;
  wire hit_frz = msr_addr == ADDR_FREEZE_CTRL;
  wire hit_of0 = msr_addr == ADDR_OFFCORE_0;
  wire hit_of1 = msr_addr == ADDR_OFFCORE_1;
  wire any_hit = hit_gp | hit_al | hit_ev | hit_fx | hit_ctrl | hit_stat
               | hit_oclr | hit_fxc | hit_cap | hit_ebs | hit_frz
               | hit_of0 | hit_of1;

  wire hi_ctr_fault = core_shared & ((hit_gp & gp_idx[2])
                    | (hit_al & al_idx[2]) | (hit_ev & ev_idx[2]));
  // ones in 7:4 of the global regs fault when shared
  wire hi_bit_fault = acc_wr & core_shared & (hit_ctrl | hit_stat | hit_oclr)
                    & (|msr_wdata[HI_MSB:HI_LSB]);
  // An unmapped address is answered with a fault as well
  wire acc_fault = msr_req & (hi_ctr_fault | hi_bit_fault | ~any_hit);
  wire wr_ok = acc_wr & ~acc_fault;

  // Write strobes
  wire gp_wr = wr_ok & (hit_gp | hit_al);
  wire [2:0] gp_wr_idx = hit_al ? al_idx : gp_idx;
  wire ctrl_wr = wr_ok & hit_ctrl;
  wire oclr_wr = wr_ok & hit_oclr;
  wire frz_wr = wr_ok & hit_frz;
  // normal write loads the sign-extended low half
  // alias write loads the full width
  wire [CTR_W-1:0] gp_wr_val = hit_al ? msr_wdata[CTR_W-1:0]
    : {{(CTR_W-SEXT_W){msr_wdata[SEXT_W-1]}}, msr_wdata[SEXT_W-1:0]};

  // ==========================================================
  // Counting enables and freeze
  // freeze while in system management mode
  wire smm_freeze = smm_active & frz_ff[FRZ_SMM_BIT];
  // interrupt freeze drops every global enable
  wire irq_freeze = monitor_irq & frz_ff[FRZ_CTR_BIT];
  logic [NUM_GP-1:0] gp_inc;
  logic [NUM_GP-1:0] gp_ld;
  logic [NUM_FIX-1:0] fix_inc;

  // ==========================================================
  // Sampling: pick the lowest armed counter that sees an event
  // next counted event after an overflow samples
  wire [EBS_COUNT-1:0] samp_hit = armed_ff & gp_inc[EBS_COUNT-1:0];
  wire samp_any = |samp_hit;
  wire [1:0] samp_idx = samp_hit[0] ? 2'd0 : samp_hit[1] ? 2'd1
                      : samp_hit[2] ? 2'd2 : 2'd3;
  wire [EBS_COUNT-1:0] samp_one = samp_any ? EBS_COUNT'(1) << samp_idx
                                : '0;
  // store only when the bounds check passes
  // failing bounds skips the store, clear and reload
  wire samp_ok = samp_any & ds_bounds_ok;
  wire [EBS_COUNT-1:0] samp_clr = samp_ok ? samp_one : '0;

  // ==========================================================
  // Per-counter logic for the general counters
  // eight counters; the top four hide when shared
  for (genvar i = 0; i < NUM_GP; i++) begin : g_gp
    localparam bit LOW = i < GP_SHARED_COUNT;
    wire sw_ld = gp_wr & (gp_wr_idx == 3'(i));
    wire smp_ld = LOW ? (samp_ok & (samp_idx == 2'(i))) : 1'b0;
    wire priv_ok = (evsel_ff[i][EVSEL_USR_BIT] & cpl_user)
                 | (evsel_ff[i][EVSEL_OS_BIT] & ~cpl_user);
    // count only while global AND privilege enable hold
    wire cnt_en = gctrl_gp_ff[i] & priv_ok & (LOW | ~core_shared)
                & ~smm_freeze;
    assign gp_inc[i] = gp_event[i] & cnt_en;
    // Software write wins over a sampling reload
    assign gp_ld[i] = sw_ld | smp_ld;
    assign gp_evsel_flat[i*EVSEL_W +: EVSEL_W] = evsel_ff[i];
    cpmc_counter #(.W(CTR_W)) u_ctr (
      .mclk(mclk),
      .rst(rst),
      .inc(gp_inc[i]),
      .load(gp_ld[i]),
      .load_val(sw_ld ? gp_wr_val : ds_reload_value),
      .count_ff(gp_cnt[i]),
      .wrap(gp_wrap[i])
    );
  end

  // Per-counter logic for the fixed counters
  for (genvar j = 0; j < NUM_FIX; j++) begin : g_fix
    wire sw_ld = wr_ok & hit_fx & (fx_idx == 2'(j));
    wire os_en = fixctl_ff[j*FIXCTL_STRIDE + FIXCTL_OS_BIT];
    wire usr_en = fixctl_ff[j*FIXCTL_STRIDE + FIXCTL_USR_BIT];
    // fixed counters obey the same AND of enables
    assign fix_inc[j] = fixed_event[j] & gctrl_fix_ff[j] & ~smm_freeze
                      & ((usr_en & cpl_user) | (os_en & ~cpl_user));
    cpmc_counter #(.W(CTR_W)) u_ctr (
      .mclk(mclk),
      .rst(rst),
      .inc(fix_inc[j]),
      .load(sw_ld),
      .load_val(msr_wdata[CTR_W-1:0]),
      .count_ff(fix_cnt[j]),
      .wrap(fix_wrap[j])
    );
  end

  // ==========================================================
  // Next values of the global registers
  wire [NUM_GP-1:0] oclr_gp = oclr_wr ? msr_wdata[NUM_GP-1:0] : '0;
  wire [NUM_FIX-1:0] oclr_fix = oclr_wr
    ? msr_wdata[FIX_LSB +: NUM_FIX] : '0;
  wire oclr_buf = oclr_wr & msr_wdata[STAT_BUF_OVF_BIT];
  // one flag per counter; set wins over clear
  // one write clears any chosen set of flags
  wire [NUM_GP-1:0] nxt_gp_ovf = (gp_ovf_ff & ~oclr_gp
    & ~{{(NUM_GP-EBS_COUNT){1'b0}}, samp_clr}) | gp_wrap;
  wire [NUM_FIX-1:0] nxt_fix_ovf = (fix_ovf_ff & ~oclr_fix) | fix_wrap;
  // buffer full sets the sticky buffer overflow flag
  wire nxt_buf_ovf = (buf_ovf_ff & ~oclr_buf) | ds_buffer_full;
  // wrap arms; only the low four arm at all
  wire [EBS_COUNT-1:0] nxt_armed = (armed_ff & ~samp_one)
                                 | (gp_wrap[EBS_COUNT-1:0] & ebs_en_ff);
  wire [7:0] enum_cnt = core_shared ? ENUM_CNT_SHARED : ENUM_CNT_FULL;
  wire [31:0] nxt_enum = {16'h0000, enum_cnt, PMU_VERSION};

  // Global enables: interrupt freeze beats a software write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gctrl_gp_ff <= '0;
      gctrl_fix_ff <= '0;
    end else if (irq_freeze) begin
      gctrl_gp_ff <= '0;
      gctrl_fix_ff <= '0;
    end else if (ctrl_wr) begin
      gctrl_gp_ff <= msr_wdata[NUM_GP-1:0];
      gctrl_fix_ff <= msr_wdata[FIX_LSB +: NUM_FIX];
    end
  end

  // Status and sampling state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gp_ovf_ff <= '0;
      fix_ovf_ff <= '0;
      buf_ovf_ff <= 1'b0;
      armed_ff <= '0;
    end else begin
      gp_ovf_ff <= nxt_gp_ovf;
      fix_ovf_ff <= nxt_fix_ovf;
      buf_ovf_ff <= nxt_buf_ovf;
      armed_ff <= nxt_armed;
    end
  end

  // Configuration registers
  // two off-core response configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ebs_en_ff <= '0;
      frz_ff <= '0;
      fixctl_ff <= '0;
      off0_ff <= REG64_RESET;
      off1_ff <= REG64_RESET;
    end else if (wr_ok) begin
      if (hit_ebs) ebs_en_ff <= msr_wdata[EBS_COUNT-1:0];
      if (hit_frz) frz_ff <= msr_wdata[2:0];
      if (hit_fxc) fixctl_ff <= msr_wdata[FIXCTL_W-1:0];
      if (hit_of0) off0_ff <= msr_wdata;
      if (hit_of1) off1_ff <= msr_wdata;
    end
  end

  // Event selects, one per general counter
  // high event selects follow their counters
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NUM_GP; k++) evsel_ff[k] <= EVSEL_RESET;
    end else if (wr_ok & hit_ev) begin
      evsel_ff[ev_idx] <= msr_wdata[EVSEL_W-1:0];
    end
  end

  // branch record freeze holds until the freeze reg is written
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      br_frz_ff <= 1'b0;
    end else if (monitor_irq & frz_ff[FRZ_BR_BIT]) begin
      br_frz_ff <= 1'b1;
    end else if (frz_wr) begin
      br_frz_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Read data selection
  logic [63:0] rd_val;
  always_comb begin
    rd_val = REG64_RESET;
    if (hit_gp) begin
      rd_val = {16'h0000, gp_cnt[gp_idx]};
    end else if (hit_al) begin
      rd_val = {16'h0000, gp_cnt[al_idx]};
    end else if (hit_ev) begin
      rd_val[EVSEL_W-1:0] = evsel_ff[ev_idx];
    end else if (hit_fx) begin
      rd_val = {16'h0000, fix_cnt[fx_idx]};
    end else if (hit_ctrl) begin
      rd_val[NUM_GP-1:0] = gctrl_gp_ff;
      rd_val[FIX_LSB +: NUM_FIX] = gctrl_fix_ff;
    end else if (hit_stat) begin
      rd_val[NUM_GP-1:0] = gp_ovf_ff;
      rd_val[FIX_LSB +: NUM_FIX] = fix_ovf_ff;
      rd_val[STAT_BUF_OVF_BIT] = buf_ovf_ff;
    end else if (hit_cap) begin
      // advertise full-width writes and alias addresses
      rd_val[CAP_FW_WRITE_BIT] = 1'b1;
    end else if (hit_fxc) begin
      rd_val[FIXCTL_W-1:0] = fixctl_ff;
    end else if (hit_ebs) begin
      rd_val[EBS_COUNT-1:0] = ebs_en_ff;
    end else if (hit_frz) begin
      rd_val[2:0] = frz_ff;
    end else if (hit_of0) begin
      rd_val = off0_ff;
    end else if (hit_of1) begin
      rd_val = off1_ff;
    end
  end

  // Access answer one cycle after the request; faulted reads keep the last read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      fault_ff <= 1'b0;
      rdata_ff <= REG64_RESET;
    end else begin
      ack_ff <= msr_req;
      fault_ff <= acc_fault;
      if (msr_req & ~msr_wr & ~acc_fault) rdata_ff <= rd_val;
    end
  end

  // Record store pulse and enumeration word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      store_ff <= 1'b0;
      store_idx_ff <= 2'd0;
      enum_ff <= 32'h0000_0000;
    end else begin
      store_ff <= samp_ok;
      if (samp_ok) store_idx_ff <= samp_idx;
      enum_ff <= nxt_enum;
    end
  end

  // ==========================================================
  // Outputs
  assign msr_ack = ack_ff;
  assign msr_fault = fault_ff;
  assign msr_rdata = rdata_ff;
  assign record_store = store_ff;
  assign record_ctr = store_idx_ff;
  assign enum_result = enum_ff;
  assign offcore_cfg0 = off0_ff;
  assign offcore_cfg1 = off1_ff;
  assign branch_record_freeze = br_frz_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_enum_count: assert property (
    1'b1 |=> enum_result[15:8] == ($past(core_shared) ? 8'd4 : 8'd8))
    else $error("enumerated counter count wrong");
  a_fault_hi_enable: assert property (
    msr_req && msr_wr && core_shared && msr_addr == ADDR_GLOBAL_CTRL
    && msr_wdata[7:4] != 4'h0 && !irq_freeze
    |=> msr_fault && $stable(gctrl_gp_ff))
    else $error("high enable write not refused");
  a_fault_hi_ctr: assert property (
    msr_req && core_shared && msr_addr >= ADDR_GP_CTR4
    && msr_addr <= ADDR_GP_CTR7 |=> msr_ack && msr_fault)
    else $error("high counter access not faulted");
  a_stop_disabled: assert property (
    !gctrl_gp_ff[0] && !gp_ld[0] |=> $stable(gp_cnt[0]))
    else $error("disabled counter moved");
  a_ovf_on_wrap: assert property (
    gp_wrap[1] |=> gp_ovf_ff[1])
    else $error("wrap did not set overflow");
  a_buf_ovf_set: assert property (
    ds_buffer_full |=> buf_ovf_ff)
    else $error("buffer overflow not flagged");
  a_arm_on_wrap: assert property (
    gp_wrap[0] && ebs_en_ff[0] |=> armed_ff[0])
    else $error("overflow did not arm sampling");
  a_sample_reload: assert property (
    samp_ok && !gp_wr |=> record_store
    && gp_cnt[record_ctr] == $past(ds_reload_value))
    else $error("sampling store did not reload");
  a_skip_no_store: assert property (
    samp_any && !ds_bounds_ok && !gp_wr
    |=> !record_store && (gp_ovf_ff[$past(samp_idx)] || $past(oclr_wr)
    || !$past(gp_ovf_ff[samp_idx])))
    else $error("failed bounds still sampled");
  a_ovf_clear: assert property (
    oclr_wr && msr_wdata[2] && !gp_wrap[2] |=> !gp_ovf_ff[2])
    else $error("overflow clear ignored");
  a_sext_write: assert property (
    wr_ok && hit_gp && gp_idx == 3'd0 |=> gp_cnt[0]
    == {{16{$past(msr_wdata[31])}}, $past(msr_wdata[31:0])})
    else $error("normal write not sign-extended");
  a_alias_write: assert property (
    wr_ok && hit_al && al_idx == 3'd1
    |=> gp_cnt[1] == $past(msr_wdata[47:0]))
    else $error("alias write not full width");
  a_cap_bit: assert property (
    msr_req && !msr_wr && hit_cap |=> msr_rdata[13])
    else $error("full-width capability missing");
  a_irq_freeze: assert property (
    irq_freeze |=> gctrl_gp_ff == '0 ##1 gctrl_gp_ff == '0 || $past(ctrl_wr))
    else $error("interrupt freeze failed");

  c_sample_store: cover property (samp_ok ##1 record_store);
  c_sample_skip: cover property (samp_any && !ds_bounds_ok);
  c_wrap_clear: cover property (gp_wrap[0] ##[1:20] oclr_wr);

endmodule

// ===== tb/cpmc_evt_model.sv
// Partner model: core event pulses and the sampling store engine.
// Assumes a record is taken on each record_store pulse.
`timescale 1ns/1ps
module cpmc_evt_model #(
  parameter int DEPTH = 1,  // Records the buffer holds
  parameter logic [47:0] RELOAD = 48'h0000_0000_0010  // Sample reload
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Store engine side
  input wire logic record_store,
  output logic ds_bounds_ok,
  output logic ds_buffer_full,
  output logic [47:0] ds_reload_value,
  // Event side
  output logic [7:0] gp_event,
  output logic [2:0] fixed_event
);
  int stored;  // Records already in the buffer
  assign ds_reload_value = RELOAD;
  // Fixed counters share the low pulses; their enables keep them apart
  assign fixed_event = gp_event[2:0];
  initial begin
    gp_event = 8'h00;
    ds_bounds_ok = 1'b1;
    ds_buffer_full = 1'b0;
  end
  // ==========================================================
  // Buffer fill; bounds fail once full, like the real engine
  always @(posedge mclk or posedge rst) begin
    if (rst)
      stored <= 0;
    else if (record_store)
      stored <= stored + 1;
  end
  // Status levels change off the sampling edge
  always @(negedge mclk) begin
    ds_bounds_ok <= stored < DEPTH;
    ds_buffer_full <= stored >= DEPTH;
  end
  // Back-to-back event pulses, one increment each
  task burst(input logic [7:0] mask, input int n);
    repeat (n) begin
      @(negedge mclk);
      gp_event = mask;
    end
    @(negedge mclk);
    gp_event = 8'h00;
  endtask
endmodule

// ===== tb/tb_top.sv
// Testbench for the core performance counter control block.
// Assumes the register port answers one edge after the request edge.
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst, msr_req, msr_wr, core_shared, cpl_user, smm_active;
  logic monitor_irq, msr_ack, msr_fault, ds_bounds_ok, ds_buffer_full;
  logic record_store, branch_record_freeze;
  logic [11:0] msr_addr;
  logic [63:0] msr_wdata, msr_rdata, offcore_cfg0, offcore_cfg1, rd;
  logic [1:0] record_ctr;
  logic [31:0] enum_result;
  logic [255:0] gp_evsel_flat;
  logic [7:0] gp_event;
  logic [2:0] fixed_event;
  logic [47:0] ds_reload_value;
  int n_mismatch, compares, n_store, cycles;
  cpmc_core_ctl uut (.mclk, .rst, .msr_req, .msr_wr, .msr_addr,
    .msr_wdata, .msr_ack, .msr_fault, .msr_rdata, .core_shared, .cpl_user,
    .smm_active, .monitor_irq, .gp_event, .fixed_event, .ds_bounds_ok,
    .ds_buffer_full, .ds_reload_value, .record_store, .record_ctr,
    .enum_result, .gp_evsel_flat, .offcore_cfg0, .offcore_cfg1,
    .branch_record_freeze);
  cpmc_evt_model ev (.mclk, .rst, .record_store, .ds_bounds_ok,
    .ds_buffer_full, .ds_reload_value, .gp_event, .fixed_event);
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // ==========================================================
  // Checks and register access
  task chk64(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle request pulse; ack and fault looked at while they stand
  task acc(input logic w, input logic [11:0] a, input logic [63:0] d,
    input logic ef);
    @(negedge mclk);
    msr_req = 1;
    msr_wr = w;
    msr_addr = a;
    msr_wdata = d;
    @(negedge mclk);
    msr_req = 0;
    compares++;
    if (msr_ack !== 1'b1 || msr_fault !== ef) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t access %h ack/fault", $time, a);
    end
    rd = msr_rdata;
  endtask
  task wr(input logic [11:0] a, input logic [63:0] d);
    acc(1, a, d, 0);
  endtask
  task rdc(input logic [11:0] a, input logic [63:0] exp);
    acc(0, a, 64'h0000_0000_0000_0000, 0);
    chk64(rd, exp);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Stores seen and hang guard
  always @(negedge mclk) begin
    cycles++;
    if (record_store === 1'b1)
      n_store++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [11:0] fa [4];
    fa = '{12'h00c5, 12'h00c8, 12'h0207, 12'h02c6};
    rst = 1;
    msr_req = 0;
    msr_wr = 0;
    msr_addr = 12'h000;
    msr_wdata = 64'h0000_0000_0000_0000;
    core_shared = 0;
    cpl_user = 1;
    smm_active = 0;
    monitor_irq = 0;
    repeat (4) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    chk64(64'(enum_result), 64'h0000_0000_0000_0803);
    rdc(12'h0320, 64'h0000_0000_0000_2000);
    acc(0, 12'h00bb, 64'h0000_0000_0000_0000, 1);
    wr(12'h01a6, 64'h0123_4567_89ab_cdef);
    wr(12'h01a7, 64'hfedc_ba98_7654_3210);
    chk64(offcore_cfg0, 64'h0123_4567_89ab_cdef);
    chk64(offcore_cfg1, 64'hfedc_ba98_7654_3210);
    $display("test register map done");
    wr(12'h00c5, 64'hffff_0000_8000_0001);
    rdc(12'h00c5, 64'h0000_ffff_8000_0001);
    wr(12'h02c4, 64'h0000_1234_5678_9abc);
    rdc(12'h00c5, 64'h0000_1234_5678_9abc);
    wr(12'h0204, 64'h0000_0000_0003_0000);
    chk64(64'(gp_evsel_flat[159:128]), 64'h0000_0000_0003_0000);
    $display("test counter writes done");
    wr(12'h0201, 64'h0000_0000_0001_0000);
    wr(12'h02c1, 64'h0000_0000_0000_0000);
    wr(12'h0322, 64'h0000_0000_0000_0003);
    ev.burst(8'h02, 5);
    rdc(12'h00c2, 64'h0000_0000_0000_0005);
    cpl_user = 0;
    ev.burst(8'h02, 3);
    cpl_user = 1;
    wr(12'h0322, 64'h0000_0000_0000_0001);
    ev.burst(8'h02, 3);
    rdc(12'h00c2, 64'h0000_0000_0000_0005);
    wr(12'h0322, 64'h0000_0000_0000_0002);
    wr(12'h0325, 64'h0000_0000_0000_0004);
    smm_active = 1;
    ev.burst(8'h02, 2);
    smm_active = 0;
    ev.burst(8'h02, 1);
    rdc(12'h00c2, 64'h0000_0000_0000_0006);
    $display("test count gating done");
    wr(12'h0200, 64'h0000_0000_0003_0000);
    wr(12'h0324, 64'h0000_0000_0000_0001);
    wr(12'h0322, 64'h0000_0000_0000_0001);
    wr(12'h02c0, 64'h0000_ffff_ffff_ffff);
    ev.burst(8'h01, 1);
    rdc(12'h0321, 64'h0000_0000_0000_0001);
    ev.burst(8'h01, 1);
    rdc(12'h00c1, 64'h0000_0000_0000_0010);
    rdc(12'h0321, 64'h4000_0000_0000_0000);
    wr(12'h02c0, 64'h0000_ffff_ffff_ffff);
    ev.burst(8'h01, 1);
    ev.burst(8'h01, 1);
    rdc(12'h0321, 64'h4000_0000_0000_0001);
    rdc(12'h00c1, 64'h0000_0000_0000_0001);
    chk64(64'(n_store), 64'h0000_0000_0000_0001);
    chk64(64'(record_ctr), 64'h0000_0000_0000_0000);
    wr(12'h0323, 64'h0000_0000_0000_0001);
    rdc(12'h0321, 64'h4000_0000_0000_0000);
    $display("test sampling done");
    wr(12'h0325, 64'h0000_0000_0000_0003);
    @(negedge mclk);
    monitor_irq = 1;
    @(negedge mclk);
    monitor_irq = 0;
    rdc(12'h0322, 64'h0000_0000_0000_0000);
    chk64(64'(branch_record_freeze), 64'h0000_0000_0000_0001);
    wr(12'h0325, 64'h0000_0000_0000_0000);
    chk64(64'(branch_record_freeze), 64'h0000_0000_0000_0000);
    wr(12'h0310, 64'h0000_0000_0000_0002);
    wr(12'h0322, 64'h0000_0001_0000_0000);
    ev.burst(8'h01, 2);
    rdc(12'h0300, 64'h0000_0000_0000_0002);
    $display("test freeze and fixed done");
    core_shared = 1;
    foreach (fa[i]) acc(0, fa[i], 64'h0000_0000_0000_0000, 1);
    for (int i = 0; i < 3; i++)
      acc(1, 12'(12'h0321 + i), 64'h0000_0000_0000_0010, 1);
    acc(0, 12'h00c4, 64'h0000_0000_0000_0000, 0);
    chk64(64'(enum_result), 64'h0000_0000_0000_0403);
    $display("test shared core done");
    give_verdict;
  end
endmodule
